// [design/pscsd_core.sv]
`timescale 1ns/1ps
module pscsd_core #(
  parameter int PORT_W = 8,
  parameter int SEL_W = 3
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [pscsd_pkg::WORD_W-1:0] instr_word,
  input wire logic [pscsd_pkg::NIB_W-1:0] acc,
  input wire logic [pscsd_pkg::NIB_W-1:0] mem_nibble,
  input wire logic [SEL_W-1:0] bit_select,
  input wire logic [pscsd_pkg::NIB_W-1:0] irq_control_reg_one,
  input wire logic ext0_request_set,
  output logic [PORT_W-1:0] port_out,
  output logic ext0_request_flag,
  output logic skip_word,
  output logic exec_word,
  output logic skip_pending
);

  // Refuse a port wider than the bit select can reach
  if (PORT_W < 1 || PORT_W > (1 << SEL_W)) begin : g_bad_width
    $error("pscsd_core: PORT_W must be 1 to 2**SEL_W");
  end

  // Whole state of the block
  typedef struct packed {
    pscsd_pkg::pscsd_state_e st;
    logic [PORT_W-1:0] port;
    logic flag;
    logic imm_match;
  } pscsd_reg_s;

  pscsd_reg_s r;
  pscsd_reg_s next_r;
  pscsd_pkg::pscsd_dec_s dec;
  logic take;
  logic exec;
  logic ext0_en;

  pscsd_decode u_decode (
    .word(instr_word),
    .dec(dec)
  );

  // A word counts only in a cycle that is enabled and carries one
  assign take = ce && instr_valid;
  assign exec = take && (r.st == pscsd_pkg::ST_RUN);
  assign ext0_en = irq_control_reg_one[pscsd_pkg::EXT0_EN_BIT];

  // Outputs; port and flag come straight from flip-flops
  assign port_out = r.port;
  assign ext0_request_flag = r.flag;
  assign skip_word = take && ((r.st == pscsd_pkg::ST_SKIP) ||
                              (r.st == pscsd_pkg::ST_SKIP_TAIL));
  assign exec_word = take && !skip_word;
  assign skip_pending = (r.st == pscsd_pkg::ST_SKIP);

  // Next-state logic; ce low leaves every field as it is
  always_comb begin
    next_r = r;
    if (take) begin
      unique case (r.st)
        pscsd_pkg::ST_RUN: begin
          unique case (dec.op)
            pscsd_pkg::OP_SET_PORT: begin
              // Out-of-range selects are ignored on a narrow port
              if (32'(bit_select) < PORT_W) begin
                next_r.port[bit_select] = 1'b1;
              end
            end
            pscsd_pkg::OP_CMP_IMM: begin
              // Compare on the first word, act after the second
              next_r.imm_match =
                pscsd_pkg::pscsd_nib_eq(acc, dec.imm);
              next_r.st = pscsd_pkg::ST_IMM_TAIL;
            end
            pscsd_pkg::OP_CMP_MEM: begin
              if (pscsd_pkg::pscsd_nib_eq(acc, mem_nibble)) begin
                next_r.st = pscsd_pkg::ST_SKIP;
              end
            end
            pscsd_pkg::OP_EXT0_TEST: begin
              if (!ext0_en) begin
                if (r.flag) begin
                  next_r.st = pscsd_pkg::ST_SKIP;
                end
                next_r.flag = 1'b0;
              end else begin
                // Enable bit high: no test, no clear, no skip
                next_r.st = pscsd_pkg::ST_RUN;
              end
            end
            pscsd_pkg::OP_OTHER: begin
              next_r.st = pscsd_pkg::ST_RUN;
            end
          endcase
        end
        pscsd_pkg::ST_IMM_TAIL: begin
          // Second word carries nothing of its own
          next_r.st = r.imm_match ? pscsd_pkg::ST_SKIP
                                  : pscsd_pkg::ST_RUN;
        end
        pscsd_pkg::ST_SKIP: begin
          // Skipped word has no effect; a two-word one takes its tail too
          next_r.st = dec.two_word ? pscsd_pkg::ST_SKIP_TAIL
                                   : pscsd_pkg::ST_RUN;
        end
        pscsd_pkg::ST_SKIP_TAIL: begin
          next_r.st = pscsd_pkg::ST_RUN;
        end
      endcase
    end
    // New request wins over a clear in the same cycle
    if (ce && ext0_request_set) begin
      next_r.flag = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r.st <= pscsd_pkg::ST_RUN;
      r.port <= '0;
      r.flag <= pscsd_pkg::FLAG_RST;
      r.imm_match <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Set instruction drives the selected bit high
  port_set_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_SET_PORT && 32'(bit_select) < PORT_W
    |=> port_out[$past(bit_select)] && $stable(r.st))
    else $error("selected port bit not set");

  // Port moves only under an executed set instruction
  port_hold_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !(exec && dec.op == pscsd_pkg::OP_SET_PORT) |=> $stable(port_out))
    else $error("port changed without set instruction");

  // Compare-immediate records the comparison and waits for its tail
  imm_compare_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_CMP_IMM
    |=> r.st == pscsd_pkg::ST_IMM_TAIL && r.imm_match ==
        ($past(acc) ==
         $past(instr_word[pscsd_pkg::IMM_LSB +: pscsd_pkg::IMM_W])))
    else $error("compare-immediate not recorded");

  // Match after the tail word leads to a skip
  imm_skip_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_IMM_TAIL && r.imm_match
    |=> r.st == pscsd_pkg::ST_SKIP)
    else $error("compare-immediate match did not skip");

  // Mismatch returns to normal execution
  imm_noskip_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_IMM_TAIL && !r.imm_match
    |=> r.st == pscsd_pkg::ST_RUN)
    else $error("compare-immediate mismatch skipped");

  // Compare-memory skips exactly on equality
  mem_skip_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_CMP_MEM
    |=> (r.st == pscsd_pkg::ST_SKIP) == ($past(acc) == $past(mem_nibble)))
    else $error("compare-memory skip wrong");

  // Flag test skips on the flag's old value when the enable bit is low
  ext0_skip_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_EXT0_TEST && !ext0_en
    |=> (r.st == pscsd_pkg::ST_SKIP) == $past(r.flag))
    else $error("flag test skip wrong");

  // Flag test clears the flag unless a new request lands
  ext0_clear_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_EXT0_TEST && !ext0_en && !ext0_request_set
    |=> !ext0_request_flag)
    else $error("flag test did not clear flag");

  // Control bit high makes the test a no-operation
  ext0_nop_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    exec && dec.op == pscsd_pkg::OP_EXT0_TEST && ext0_en
    |=> r.st == pscsd_pkg::ST_RUN &&
        ext0_request_flag == ($past(r.flag) || $past(ext0_request_set)))
    else $error("disabled flag test acted");

  // A skipped two-word instruction swallows its tail as well
  skip_tail_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_SKIP && dec.two_word
    |=> r.st == pscsd_pkg::ST_SKIP_TAIL)
    else $error("two-word skip lost its tail");

  // A skipped one-word instruction ends the skip at once
  skip_end_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_SKIP && !dec.two_word
    |=> r.st == pscsd_pkg::ST_RUN)
    else $error("one-word skip did not end");

  // The swallowed tail word ends the skip
  tail_end_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_SKIP_TAIL
    |=> r.st == pscsd_pkg::ST_RUN)
    else $error("skip tail did not end");

  // A skipped flag test must not clear the flag
  skip_flag_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    take && r.st == pscsd_pkg::ST_SKIP &&
    dec.op == pscsd_pkg::OP_EXT0_TEST && r.flag
    |=> ext0_request_flag)
    else $error("skipped flag test cleared flag");

  // Request set wins over the clear
  flag_set_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    ce && ext0_request_set |=> ext0_request_flag)
    else $error("request lost");

endmodule

// [design/pscsd_decode.sv]
`timescale 1ns/1ps
module pscsd_decode (
  input wire logic [pscsd_pkg::WORD_W-1:0] word,
  output pscsd_pkg::pscsd_dec_s dec
);

  // Pure decode; the sequencer decides whether the word is an opcode
  always_comb begin
    dec.imm = word[pscsd_pkg::IMM_LSB +: pscsd_pkg::IMM_W];
    if (word == pscsd_pkg::OPC_SET_PORT) begin
      dec.op = pscsd_pkg::OP_SET_PORT;
    end else if ((word & pscsd_pkg::OPC_CMP_IMM_MASK) ==
                 pscsd_pkg::OPC_CMP_IMM) begin
      dec.op = pscsd_pkg::OP_CMP_IMM;
    end else if (word == pscsd_pkg::OPC_CMP_MEM) begin
      dec.op = pscsd_pkg::OP_CMP_MEM;
    end else if (word == pscsd_pkg::OPC_EXT0_TEST) begin
      dec.op = pscsd_pkg::OP_EXT0_TEST;
    end else begin
      dec.op = pscsd_pkg::OP_OTHER;
    end
    // Needed so a skip also swallows a second word
    dec.two_word = (dec.op == pscsd_pkg::OP_CMP_IMM);
  end

endmodule

// [design/pscsd_pkg.sv]
package pscsd_pkg;

  // Instruction word width and opcode patterns
  localparam int WORD_W = 10;
  localparam logic [9:0] OPC_SET_PORT = 10'h015;
  localparam logic [9:0] OPC_CMP_IMM = 10'h070;
  localparam logic [9:0] OPC_CMP_IMM_MASK = 10'h3f0;
  localparam logic [9:0] OPC_CMP_MEM = 10'h026;
  localparam logic [9:0] OPC_EXT0_TEST = 10'h038;

  // Immediate field of the compare-immediate word
  localparam int IMM_LSB = 0;
  localparam int IMM_W = 4;

  // Nibble width and the enable bit inside irq_control_reg_one
  localparam int NIB_W = 4;
  localparam int EXT0_EN_BIT = 0;

  // Reset values
  localparam logic FLAG_RST = 1'b0;

  // Decoded operation classes
  typedef enum logic [2:0] {
    OP_OTHER,
    OP_SET_PORT,
    OP_CMP_IMM,
    OP_CMP_MEM,
    OP_EXT0_TEST
  } pscsd_op_e;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IMM_TAIL,
    ST_SKIP,
    ST_SKIP_TAIL
  } pscsd_state_e;

  // Output of the word decoder
  typedef struct packed {
    pscsd_op_e op;
    logic [IMM_W-1:0] imm;
    logic two_word;
  } pscsd_dec_s;

  // Nibble equality, used by both compare instructions
  function automatic logic pscsd_nib_eq(input logic [NIB_W-1:0] a,
                                        input logic [NIB_W-1:0] b);
    pscsd_nib_eq = (a == b);
  endfunction

endpackage

// [verif/pscsd_tb.sv]
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic instr_valid = 1'b0;
  logic [9:0] instr_word = 10'h000;
  logic [3:0] acc = 4'h0;
  logic [3:0] mem_nibble = 4'h0;
  logic [2:0] bit_select = 3'h0;
  logic [3:0] irq_control_reg_one = 4'h0;
  logic ext0_request_set = 1'b0;
  logic [7:0] port_out;
  logic ext0_request_flag;
  logic skip_word;
  logic exec_word;
  logic skip_pending;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] exp_port = 8'h00;

  pscsd_core dut_u (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .instr_valid(instr_valid), .instr_word(instr_word), .acc(acc),
    .mem_nibble(mem_nibble), .bit_select(bit_select),
    .irq_control_reg_one(irq_control_reg_one),
    .ext0_request_set(ext0_request_set), .port_out(port_out),
    .ext0_request_flag(ext0_request_flag), .skip_word(skip_word),
    .exec_word(exec_word), .skip_pending(skip_pending));

  // 50 MHz core clock
  always #10 ref_clk = ~ref_clk;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  // One take; suppression is combinational, so judged before the edge
  task automatic step(input logic [9:0] w, input logic skip);
    @(negedge ref_clk);
    instr_word = w;
    instr_valid = 1'b1;
    #1;
    chk("skip_word", {7'h00, skip}, {7'h00, skip_word});
    chk("exec_word", {7'h00, ~skip}, {7'h00, exec_word});
    @(posedge ref_clk);
  endtask

  // Drop valid; later input changes land here, away from the edge
  task automatic idle();
    @(negedge ref_clk);
    instr_valid = 1'b0;
    #1;
  endtask

  task automatic chk_sp(input logic exp);
    chk("skip_pending", {7'h00, exp}, {7'h00, skip_pending});
  endtask

  task automatic chk_flag(input logic exp);
    chk("ext0_request_flag", {7'h00, exp}, {7'h00, ext0_request_flag});
  endtask

  task automatic t_cmp_imm();
    for (int n = 0; n < 16; n++) begin
      acc = n[3:0];
      bit_select = n[2:0];
      step(10'h070 | 10'(n), 1'b0);
      step(10'h3ff, 1'b0);
      idle();
      chk_sp(1'b1);
      step(10'h015, 1'b1);
      idle();
      chk("port_out", exp_port, port_out);
      chk_sp(1'b0);
      acc = n[3:0] ^ 4'h1;
      step(10'h070 | 10'(n), 1'b0);
      step(10'h3ff, 1'b0);
      step(10'h000, 1'b0);
      idle();
      chk_sp(1'b0);
    end
    $display("test cmp_imm done");
  endtask

  // A skipped two-word compare swallows both of its words
  task automatic t_skip2();
    acc = 4'h3;
    bit_select = 3'h2;
    step(10'h073, 1'b0);
    step(10'h3ff, 1'b0);
    step(10'h073, 1'b1);
    step(10'h3ff, 1'b1);
    step(10'h015, 1'b0);
    idle();
    exp_port[2] = 1'b1;
    chk("port_out", exp_port, port_out);
    $display("test skip2 done");
  endtask

  task automatic t_cmp_mem();
    acc = 4'h9;
    mem_nibble = 4'h9;
    step(10'h026, 1'b0);
    idle();
    chk_sp(1'b1);
    step(10'h000, 1'b1);
    idle();
    acc = 4'h8;
    step(10'h026, 1'b0);
    step(10'h000, 1'b0);
    idle();
    $display("test cmp_mem done");
  endtask

  task automatic pulse();
    @(negedge ref_clk);
    ext0_request_set = 1'b1;
    @(negedge ref_clk);
    ext0_request_set = 1'b0;
    #1;
  endtask

  task automatic t_ext();
    irq_control_reg_one = 4'h0;
    pulse();
    chk_flag(1'b1);
    step(10'h038, 1'b0);
    idle();
    chk_flag(1'b0);
    chk_sp(1'b1);
    step(10'h000, 1'b1);
    step(10'h038, 1'b0);
    step(10'h000, 1'b0);
    idle();
    irq_control_reg_one = 4'h1;
    pulse();
    step(10'h038, 1'b0);
    step(10'h000, 1'b0);
    idle();
    chk_flag(1'b1);
    $display("test ext done");
  endtask

  // Skipped flag test, set and clear in one cycle, then ce held low
  task automatic t_flag_ce();
    irq_control_reg_one = 4'h0;
    acc = 4'h6;
    mem_nibble = 4'h6;
    step(10'h026, 1'b0);
    step(10'h038, 1'b1);
    idle();
    chk_flag(1'b1);
    step(10'h038, 1'b0);
    step(10'h000, 1'b1);
    // Request lands in the very cycle of the clearing test
    @(negedge ref_clk);
    instr_word = 10'h038;
    instr_valid = 1'b1;
    ext0_request_set = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    ext0_request_set = 1'b0;
    #1;
    chk_flag(1'b1);
    chk_sp(1'b0);
    // Words offered with ce low must change nothing
    @(negedge ref_clk);
    ce = 1'b0;
    bit_select = 3'h5;
    instr_word = 10'h015;
    instr_valid = 1'b1;
    #1;
    chk("exec_word", 8'h00, {7'h00, exec_word});
    chk("skip_word", 8'h00, {7'h00, skip_word});
    @(negedge ref_clk);
    instr_word = 10'h038;
    #1;
    chk("exec_word", 8'h00, {7'h00, exec_word});
    @(negedge ref_clk);
    instr_valid = 1'b0;
    ce = 1'b1;
    #1;
    chk("port_out", exp_port, port_out);
    chk_flag(1'b1);
    chk_sp(1'b0);
    step(10'h038, 1'b0);
    step(10'h000, 1'b1);
    // A request with ce low is ignored as well
    @(negedge ref_clk);
    instr_valid = 1'b0;
    ce = 1'b0;
    ext0_request_set = 1'b1;
    @(negedge ref_clk);
    ext0_request_set = 1'b0;
    ce = 1'b1;
    #1;
    chk_flag(1'b0);
    $display("test flag_ce done");
  endtask

  task automatic t_port();
    for (int i = 0; i < 8; i++) begin
      bit_select = i[2:0];
      step(10'h015, 1'b0);
      idle();
      exp_port[i] = 1'b1;
      chk("port_out", exp_port, port_out);
    end
    $display("test port done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reset for 16 cycles, then the tests in order
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    chk("port_out", 8'h00, port_out);
    t_cmp_imm();
    t_skip2();
    t_cmp_mem();
    t_ext();
    t_flag_ce();
    t_port();
    end_of_test();
  end
endmodule
